// ---- gpd_regs.vh ----
// Register map, field layout and reset values of the GPIO port block.
// Assumes a 9-bit Avalon-MM byte address, 32-bit data, one word per register.
`ifndef GPD_REGS_VH
`define GPD_REGS_VH

// Port and pin counts
`define GPD_NUM_PORTS 5
`define GPD_NUM_PINS 40
`define GPD_PORT_W 8

// Implemented pins per port (unimplemented bits ignore writes, read as zero)
`define GPD_MASK_P0 8'hff
`define GPD_MASK_P1 8'hff
`define GPD_MASK_P2 8'h3f
`define GPD_MASK_P3 8'h3f
`define GPD_MASK_P4 8'hff

// Address layout: byte address [8:6] = port, [5:2] = register
`define GPD_ADDR_W 9
`define GPD_PORT_LSB 6
`define GPD_REG_LSB 2

// Register indexes within a port block (byte offset = 4 * index)
`define GPD_REG_OUT 4'h0
`define GPD_REG_PIN 4'h1
`define GPD_REG_MODE 4'h2
`define GPD_REG_BUF 4'h3
`define GPD_REG_SEL 4'h4
`define GPD_REG_EDGE 4'h5
`define GPD_REG_ISTAT 4'h6
`define GPD_REG_ICLR 4'h7
`define GPD_REG_IEN 4'h8

// Fields of the buffer control register
`define GPD_BUF_IBUF_LSB 0
`define GPD_BUF_OBUF_LSB 8
`define GPD_BUF_LVTTL_BIT 16
`define GPD_BUF_SLOW_BIT 17

// Drive modes (3 bits per pin)
`define GPD_DM_ANALOG 3'h0
`define GPD_DM_INPUT 3'h1
`define GPD_DM_RES_UP 3'h2
`define GPD_DM_RES_DOWN 3'h3
`define GPD_DM_OD_LOW 3'h4
`define GPD_DM_OD_HIGH 3'h5
`define GPD_DM_STRONG 3'h6
`define GPD_DM_WEAK 3'h7

// Edge selection (2 bits per pin)
`define GPD_EDGE_NONE 2'h0
`define GPD_EDGE_RISE 2'h1
`define GPD_EDGE_FALL 2'h2
`define GPD_EDGE_BOTH 2'h3

// Output source select (2 bits per pin): data register or alternate 1..3
`define GPD_SRC_DATA 2'h0
`define GPD_SRC_ALT1 2'h1
`define GPD_SRC_ALT2 2'h2
`define GPD_SRC_ALT3 2'h3

// Reset values
`define GPD_RST_WORD 32'h00000000
`endif

// ---- gpd_pad.v ----
// One pin cell: drive-mode decode, buffer gating, registered pad controls,
// and a two-stage input synchroniser. Assumes pad inputs may be asynchronous.
`timescale 1ns/10ps
`include "gpd_regs.vh"
module gpd_pad (
  input wire clk,
  input wire rst,
  input wire [2:0] mode,
  input wire dout,
  input wire ibuf_en,
  input wire obuf_en,
  input wire lvttl,
  input wire slow,
  input wire pad_in,
  output reg pad_out,
  output reg pad_oe,
  output reg pad_weak,
  output reg pad_ie,
  output reg pad_lvttl,
  output reg pad_slow,
  output reg sync_lvl,
  output reg sync_prev
);
  reg sync_meta;
  reg next_oe;
  reg next_weak;

  // Drive decode: which levels are driven, and how strongly
  always @* begin
    next_oe = 1'b0;
    next_weak = 1'b0;
    case (mode)
      `GPD_DM_ANALOG: next_oe = 1'b0;
      `GPD_DM_INPUT: next_oe = 1'b0;
      `GPD_DM_RES_UP: begin
        next_oe = 1'b1;
        next_weak = dout;
      end
      `GPD_DM_RES_DOWN: begin
        next_oe = 1'b1;
        next_weak = ~dout;
      end
      `GPD_DM_OD_LOW: next_oe = ~dout;
      `GPD_DM_OD_HIGH: next_oe = dout;
      `GPD_DM_STRONG: next_oe = 1'b1;
      `GPD_DM_WEAK: begin
        next_oe = 1'b1;
        next_weak = 1'b1;
      end
      default: next_oe = 1'b0;
    endcase
  end

  // Pad control registers; reset leaves the pin fully disabled
  always @(posedge clk) begin
    if (rst) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pad_weak <= 1'b0;
      pad_ie <= 1'b0;
      pad_lvttl <= 1'b0;
      pad_slow <= 1'b0;
    end else begin
      pad_out <= dout;
      pad_oe <= next_oe & obuf_en;
      pad_weak <= next_weak & next_oe & obuf_en;
      pad_ie <= ibuf_en & (mode != `GPD_DM_ANALOG);
      pad_lvttl <= lvttl;
      pad_slow <= slow;
    end
  end

  // Two-stage synchroniser, then one delayed copy for edge detection
  always @(posedge clk) begin
    if (rst) begin
      sync_meta <= 1'b0;
      sync_lvl <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= pad_in;
      sync_lvl <= sync_meta;
      sync_prev <= sync_lvl;
    end
  end
endmodule

// ---- gpd_port.v ----
// GPIO port block: five 8-bit ports, register file on Avalon-MM, pin cells,
// per-pin edge interrupts and one interrupt line per port.
// Assumes a single clock, synchronous active-high reset, pads outside.
`timescale 1ns/10ps
`include "gpd_regs.vh"
module gpd_port (
  input wire clk,
  input wire rst,
  input wire [8:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [39:0] alt1_out,
  input wire [39:0] alt2_out,
  input wire [39:0] alt3_out,
  input wire [39:0] pad_in,
  output wire [39:0] pad_out,
  output wire [39:0] pad_oe,
  output wire [39:0] pad_weak,
  output wire [39:0] pad_ie,
  output wire [39:0] pad_lvttl,
  output wire [39:0] pad_slow,
  output reg [4:0] irq
);
  // Software-visible state, packed per pin (lvttl_sel and slow_sel per port)
  reg [39:0] out_data;
  reg [119:0] drive_mode;
  reg [39:0] ibuf_en;
  reg [39:0] obuf_en;
  reg [4:0] lvttl_sel;
  reg [4:0] slow_sel;
  reg [79:0] src_sel;
  reg [79:0] edge_sel;
  reg [39:0] int_en;
  reg [39:0] int_stat;
  reg [31:0] next_rdata;
  reg [39:0] drive_bit;
  wire [39:0] sync_lvl;
  wire [39:0] sync_prev;
  wire [39:0] pin_event;
  wire [2:0] port_idx;
  wire [3:0] reg_idx;
  wire port_ok;
  wire wr_go;
  wire [23:0] pair_mask;
  integer k;
  integer j;
  integer n;

  // Implemented-pin mask of a port
  function [7:0] port_mask;
    input [2:0] p;
    begin
      case (p)
        3'h0: port_mask = `GPD_MASK_P0;
        3'h1: port_mask = `GPD_MASK_P1;
        3'h2: port_mask = `GPD_MASK_P2;
        3'h3: port_mask = `GPD_MASK_P3;
        3'h4: port_mask = `GPD_MASK_P4;
        default: port_mask = 8'h00;
      endcase
    end
  endfunction

  // Widens a pin mask to a field mask of w bits per pin (w is 2 or 3)
  function [23:0] field_mask;
    input [7:0] m;
    input [1:0] w;
    integer i;
    begin
      field_mask = 24'h000000;
      for (i = 0; i < 8; i = i + 1) begin
        if (m[i]) begin
          if (w == 2'h3) begin
            field_mask[i*3 +: 3] = 3'h7;
          end else begin
            field_mask[i*2 +: 2] = 2'h3;
          end
        end
      end
    end
  endfunction

  // Address decode
  assign port_idx = avs_address[`GPD_PORT_LSB +: 3];
  assign reg_idx = avs_address[`GPD_REG_LSB +: 4];
  assign port_ok = (port_idx < `GPD_NUM_PORTS);
  assign wr_go = avs_write & ~avs_waitrequest & port_ok;
  // Two-bit-per-pin write mask of the addressed port
  assign pair_mask = field_mask(port_mask(port_idx), 2'h2);

  // Output source mux per pin
  always @* begin
    drive_bit = 40'h0000000000;
    for (k = 0; k < 40; k = k + 1) begin
      case (src_sel[k*2 +: 2])
        `GPD_SRC_DATA: drive_bit[k] = out_data[k];
        `GPD_SRC_ALT1: drive_bit[k] = alt1_out[k];
        `GPD_SRC_ALT2: drive_bit[k] = alt2_out[k];
        `GPD_SRC_ALT3: drive_bit[k] = alt3_out[k];
        default: drive_bit[k] = out_data[k];
      endcase
    end
  end

  // One pin cell per bit position; unimplemented cells stay in analog mode
  genvar g;
  generate
    for (g = 0; g < 40; g = g + 1) begin : pin
      gpd_pad u_pad (
        .clk(clk),
        .rst(rst),
        .mode(drive_mode[g*3 +: 3]),
        .dout(drive_bit[g]),
        .ibuf_en(ibuf_en[g]),
        .obuf_en(obuf_en[g]),
        .lvttl(lvttl_sel[g/8]),
        .slow(slow_sel[g/8]),
        .pad_in(pad_in[g]),
        .pad_out(pad_out[g]),
        .pad_oe(pad_oe[g]),
        .pad_weak(pad_weak[g]),
        .pad_ie(pad_ie[g]),
        .pad_lvttl(pad_lvttl[g]),
        .pad_slow(pad_slow[g]),
        .sync_lvl(sync_lvl[g]),
        .sync_prev(sync_prev[g])
      );
      // Edge detection on synchronised level while the input buffer is on
      assign pin_event[g] = pad_ie[g] & (
        (edge_sel[g*2] & sync_lvl[g] & ~sync_prev[g]) |
        (edge_sel[g*2+1] & ~sync_lvl[g] & sync_prev[g]));
    end
  endgenerate

  // Read data selection
  always @* begin
    next_rdata = 32'h00000000;
    if (port_ok) begin
      case (reg_idx)
        `GPD_REG_OUT: next_rdata = {24'h000000, out_data[port_idx*8 +: 8]};
        `GPD_REG_PIN: next_rdata = {24'h000000, sync_lvl[port_idx*8 +: 8] & pad_ie[port_idx*8 +: 8]};
        `GPD_REG_MODE: next_rdata = {8'h00, drive_mode[port_idx*24 +: 24]};
        `GPD_REG_BUF: next_rdata = {14'h0000, slow_sel[port_idx], lvttl_sel[port_idx],
                                    obuf_en[port_idx*8 +: 8], ibuf_en[port_idx*8 +: 8]};
        `GPD_REG_SEL: next_rdata = {16'h0000, src_sel[port_idx*16 +: 16]};
        `GPD_REG_EDGE: next_rdata = {16'h0000, edge_sel[port_idx*16 +: 16]};
        `GPD_REG_ISTAT: next_rdata = {24'h000000, int_stat[port_idx*8 +: 8]};
        `GPD_REG_IEN: next_rdata = {24'h000000, int_en[port_idx*8 +: 8]};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // Bus handshake: one wait cycle, then the request completes
  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `GPD_RST_WORD;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? next_rdata : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Configuration registers; writes touch only implemented pins
  always @(posedge clk) begin
    if (rst) begin
      out_data <= 40'h0000000000;
      drive_mode <= 120'h0;
      ibuf_en <= 40'h0000000000;
      obuf_en <= 40'h0000000000;
      lvttl_sel <= 5'h00;
      slow_sel <= 5'h00;
      src_sel <= 80'h0;
      edge_sel <= 80'h0;
      int_en <= 40'h0000000000;
    end else if (wr_go) begin
      case (reg_idx)
        `GPD_REG_OUT: out_data[port_idx*8 +: 8] <= avs_writedata[7:0] & port_mask(port_idx);
        `GPD_REG_MODE: drive_mode[port_idx*24 +: 24] <=
          avs_writedata[23:0] & field_mask(port_mask(port_idx), 2'h3);
        `GPD_REG_BUF: begin
          ibuf_en[port_idx*8 +: 8] <= avs_writedata[`GPD_BUF_IBUF_LSB +: 8] & port_mask(port_idx);
          obuf_en[port_idx*8 +: 8] <= avs_writedata[`GPD_BUF_OBUF_LSB +: 8] & port_mask(port_idx);
          lvttl_sel[port_idx] <= avs_writedata[`GPD_BUF_LVTTL_BIT];
          slow_sel[port_idx] <= avs_writedata[`GPD_BUF_SLOW_BIT];
        end
        `GPD_REG_SEL: src_sel[port_idx*16 +: 16] <= avs_writedata[15:0] & pair_mask[15:0];
        `GPD_REG_EDGE: edge_sel[port_idx*16 +: 16] <= avs_writedata[15:0] & pair_mask[15:0];
        `GPD_REG_IEN: int_en[port_idx*8 +: 8] <= avs_writedata[7:0] & port_mask(port_idx);
        default: out_data <= out_data;
      endcase
    end
  end

  // Sticky status: a new event wins over a same-cycle write-one clear
  always @(posedge clk) begin
    if (rst) begin
      int_stat <= 40'h0000000000;
    end else begin
      for (j = 0; j < 40; j = j + 1) begin
        if (pin_event[j]) begin
          int_stat[j] <= 1'b1;
        end else if (wr_go && reg_idx == `GPD_REG_ICLR && port_idx == j / 8 && avs_writedata[j % 8]) begin
          int_stat[j] <= 1'b0;
        end
      end
    end
  end

  // One request line per port, high while any enabled status bit is set
  always @(posedge clk) begin
    if (rst) begin
      irq <= 5'h00;
    end else begin
      for (n = 0; n < 5; n = n + 1) begin
        irq[n] <= |(int_stat[n*8 +: 8] & int_en[n*8 +: 8]);
      end
    end
  end
endmodule

// ---- gpd_port_checker.sv ----
// Assertion checker for the GPIO port block, bound to gpd_port.
// Sees only the block's ports; one clock, synchronous reset.
`timescale 1ns/10ps
module gpd_port_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [39:0] pad_in,
  input wire logic [39:0] pad_oe,
  input wire logic [39:0] pad_ie,
  input wire logic [39:0] pad_lvttl,
  input wire logic [39:0] pad_slow,
  input wire logic [4:0] irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic commit;
  logic [39:0] prev_in;
  logic [3:0] calm;
  // Write taking effect at this edge
  assign commit = avs_write && !avs_waitrequest;
  // Cycles since the last pad change or committed write, saturating
  always_ff @(posedge clk) begin
    prev_in <= pad_in;
    if (rst || pad_in != prev_in || commit) calm <= 4'h0;
    else if (calm != 4'hf) calm <= calm + 4'h1;
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_hole;
    avs_read && avs_address[8:6] > 3'h4 && avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_RST_PADS: assert property (disable iff (1'b0) rst [*2] |=> pad_oe == 40'h0 && pad_ie == 40'h0)
    else $error("pad driven during reset");
  AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");
  AST_HOLE_RD: assert property (s_hole |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UNIMPL: assert property ((pad_oe[23:22] | pad_oe[31:30] | pad_ie[23:22] | pad_ie[31:30]) == 2'h0)
    else $error("missing pin enabled");
  AST_LVTTL: assert property (pad_lvttl[7:0] inside {8'h00, 8'hff})
    else $error("threshold differs within port");
  AST_SLOW: assert property (pad_slow[39:32] inside {8'h00, 8'hff})
    else $error("slew differs within port");
  AST_IE_CAUSE: assert property (!$stable(pad_ie) |-> $past(commit, 2))
    else $error("input buffer changed without write");
  AST_IRQ_CAUSE: assert property (|(irq & ~$past(irq)) |-> calm < 4'h8)
    else $error("irq rose without cause");
endmodule

bind gpd_port gpd_port_checker u_gpd_port_checker (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .pad_in(pad_in), .pad_oe(pad_oe), .pad_ie(pad_ie),
  .pad_lvttl(pad_lvttl), .pad_slow(pad_slow), .irq(irq));

// ---- gpd_pad_model.sv ----
// Board-side model of the pins.
// Assumes a released pin settles to the level the board puts on it.
`timescale 1ns/10ps
module gpd_pad_model (
  input wire logic [39:0] pad_out,
  input wire logic [39:0] pad_oe,
  input wire logic [39:0] board,
  output logic [39:0] pad_in
);
  // Driven pins follow the block, released pins the board
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board);
endmodule

// ---- test_gpio_port_drive_and_irq.sv ----
// Self-checking bench for the GPIO port block with a board model.
// Assumes a 25 MHz clock and the register map of gpd_regs.vh.
`timescale 1ns/10ps
`include "gpd_regs.vh"
module test_gpio_port_drive_and_irq;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] avs_address = 9'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  logic [39:0] alt1_out = 40'h0;
  logic [39:0] alt2_out = 40'h1;
  logic [39:0] alt3_out = 40'h0;
  logic [39:0] board = 40'h0;
  logic [39:0] pad_in, pad_out, pad_oe, pad_weak, pad_ie, pad_lvttl, pad_slow;
  logic [4:0] irq;
  logic [3:0] e;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // Rows: mode, data, then expected oe, out, weak, ie of pin 0
  logic [7:0] rows [16] = '{8'h00, 8'h10, 8'h21, 8'h31, 8'h49, 8'h5f, 8'h6b, 8'h7d,
    8'h89, 8'h91, 8'ha1, 8'hbd, 8'hc9, 8'hdd, 8'heb, 8'hff};
  always #20 clk = ~clk;
  gpd_port u_gpd_port (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alt1_out(alt1_out), .alt2_out(alt2_out), .alt3_out(alt3_out),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_weak(pad_weak), .pad_ie(pad_ie),
    .pad_lvttl(pad_lvttl), .pad_slow(pad_slow), .irq(irq));
  gpd_pad_model u_gpd_pad_model (.pad_out(pad_out), .pad_oe(pad_oe), .board(board), .pad_in(pad_in));
  task automatic results();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] p, input logic [3:0] r, input logic [31:0] d);
    bus(1'b1, {p, r, 2'b00}, d);
  endtask
  task automatic rdchk(input logic [2:0] p, input logic [3:0] r, input logic [31:0] x);
    bus(1'b0, {p, r, 2'b00}, 32'h0);
    chk({8'h0, rd}, {8'h0, x});
  endtask
  // Cycle ceiling against a hung run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pad_oe | pad_ie, 40'h0);
    rdchk(3'h0, `GPD_REG_MODE, 32'h0);
    wr(3'h0, `GPD_REG_BUF, 32'h00030101);
    @(posedge clk);
    chk(pad_lvttl, 40'hff);
    chk(pad_slow, 40'hff);
    foreach (rows[i]) begin
      e = rows[i][3:0];
      wr(3'h0, `GPD_REG_OUT, {31'h0, rows[i][4]});
      wr(3'h0, `GPD_REG_MODE, {29'h0, rows[i][7:5]});
      @(posedge clk);
      chk({pad_oe[0], pad_out[0] & e[3], pad_weak[0] & e[3], pad_ie[0]}, e);
      repeat (2) @(posedge clk);
      rdchk(3'h0, `GPD_REG_PIN, {31'h0, e[0] & e[3] & e[2]});
    end
    wr(3'h0, `GPD_REG_BUF, 32'h00030001);
    @(posedge clk);
    chk({pad_oe[0], pad_ie[0]}, 40'h1);
    wr(3'h0, `GPD_REG_BUF, 32'h00030101);
    wr(3'h0, `GPD_REG_MODE, 32'h6);
    wr(3'h0, `GPD_REG_SEL, 32'h1);
    @(posedge clk);
    chk(pad_out[0], 40'h0);
    alt1_out <= 40'h1;
    repeat (2) @(posedge clk);
    chk(pad_out[0], 40'h1);
    // Only the selected source is high in each step
    alt1_out <= 40'h0;
    wr(3'h0, `GPD_REG_OUT, 32'h0);
    wr(3'h0, `GPD_REG_SEL, 32'h2);
    @(posedge clk);
    chk(pad_out[0], 40'h1);
    alt2_out <= 40'h0;
    alt3_out <= 40'h1;
    wr(3'h0, `GPD_REG_SEL, 32'h3);
    @(posedge clk);
    chk(pad_out[0], 40'h1);
    wr(3'h2, `GPD_REG_MODE, 32'h00db6db6);
    wr(3'h2, `GPD_REG_BUF, 32'h0000ffff);
    @(posedge clk);
    chk(pad_oe[23:16], 40'h3f);
    rdchk(3'h2, `GPD_REG_BUF, 32'h00003f3f);
    wr(3'h5, `GPD_REG_OUT, 32'hff);
    rdchk(3'h5, `GPD_REG_OUT, 32'h0);
    wr(3'h1, `GPD_REG_MODE, 32'h200);
    wr(3'h1, `GPD_REG_BUF, 32'h8);
    wr(3'h1, `GPD_REG_EDGE, 32'h40);
    wr(3'h1, `GPD_REG_IEN, 32'h8);
    board[11] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(irq, 40'h2);
    rdchk(3'h1, `GPD_REG_ISTAT, 32'h8);
    wr(3'h1, `GPD_REG_ICLR, 32'h8);
    rdchk(3'h1, `GPD_REG_ISTAT, 32'h0);
    chk(irq, 40'h0);
    board[11] <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(3'h1, `GPD_REG_ISTAT, 32'h0);
    wr(3'h1, `GPD_REG_IEN, 32'h0);
    board[11] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(irq, 40'h0);
    rdchk(3'h1, `GPD_REG_ISTAT, 32'h8);
    wr(3'h1, `GPD_REG_IEN, 32'h8);
    repeat (2) @(posedge clk);
    chk(irq, 40'h2);
    wr(3'h1, `GPD_REG_ICLR, 32'h8);
    wr(3'h1, `GPD_REG_EDGE, 32'hc0);
    board[11] <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(3'h1, `GPD_REG_ISTAT, 32'h8);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pad_oe | pad_ie, 40'h0);
    chk({35'h0, irq}, 40'h0);
    rdchk(3'h1, `GPD_REG_IEN, 32'h0);
    // Falling-edge select on port 4 pin 0: a rise is ignored, a fall raises line 4
    wr(3'h4, `GPD_REG_MODE, 32'h1);
    wr(3'h4, `GPD_REG_BUF, 32'h1);
    wr(3'h4, `GPD_REG_EDGE, 32'h2);
    wr(3'h4, `GPD_REG_IEN, 32'h1);
    board[32] <= 1'b1;
    repeat (6) @(posedge clk);
    chk({35'h0, irq}, 40'h0);
    board[32] <= 1'b0;
    repeat (6) @(posedge clk);
    chk({35'h0, irq}, 40'h10);
    rdchk(3'h4, `GPD_REG_ISTAT, 32'h1);
    results();
  end
endmodule
